// file: design/crs_counter_regs.vh
// Register map, field positions, reset values and command codes of the counter group.
`ifndef CRS_COUNTER_REGS_VH
`define CRS_COUNTER_REGS_VH

// Byte offsets of the Wishbone registers.
`define CRS_OFF_MODE       8'h00
`define CRS_OFF_LOAD       8'h04
`define CRS_OFF_HOLD       8'h08
`define CRS_OFF_CMD        8'h0c
`define CRS_OFF_STAT       8'h10
`define CRS_OFF_CNT        8'h14
`define CRS_OFF_CTRL       8'h18

// Reset values.
`define CRS_MODE_RESET     16'h0800
`define CRS_LOAD_RESET     16'h0000
`define CRS_HOLD_RESET     16'h0000
`define CRS_CNT_RESET      16'h0000

// Fields of counter_mode_config.
`define CRS_FORM_LSB       0
`define CRS_FORM_MSB       2
`define CRS_DIR_BIT        3
`define CRS_BCD_BIT        4
`define CRS_REPEAT_BIT     5
`define CRS_RELOAD_BIT     6
`define CRS_SPECIAL_BIT    7
`define CRS_POL_BIT        12
`define CRS_GATE_LSB       13
`define CRS_GATE_MSB       15
`define CRS_GATE_NONE      3'h0

// Output form codes held in output_form_bits.
`define CRS_FORM_LOW       3'h0
`define CRS_FORM_PULSE_HI  3'h1
`define CRS_FORM_TOGGLE    3'h2
`define CRS_FORM_OFF       3'h4
`define CRS_FORM_PULSE_LO  3'h5

// Command register bits.
`define CRS_CMD_ARM        0
`define CRS_CMD_LOAD       1
`define CRS_CMD_LDARM      2
`define CRS_CMD_HALT       3
`define CRS_CMD_SET        4
`define CRS_CMD_CLR        5
`define CRS_CMD_INIT       6

// Status register bits.
`define CRS_ST_ARMED       0
`define CRS_ST_RUN         1
`define CRS_ST_TC          2
`define CRS_ST_TOG         3

// Control register bits.
`define CRS_CTRL_SAVE      0

// Terminal count look-ahead values.
`define CRS_PRE_DOWN       16'h0001
`define CRS_PRE_BCD_UP     16'h9999
`define CRS_PRE_BIN_UP     16'hffff

`endif

// file: design/crs_edge_det.v
// Edge detector for a synchronous pin with selectable active edge.
`timescale 1ns/1ps
module crs_edge_det (
  // Clock and reset.
  input  wire sys_clk,
  input  wire nrst,
  // Sampled level and edge choice.
  input  wire sig_in,
  input  wire fall_sel,
  // One-cycle pulse on the chosen edge.
  output wire edge_o
);

  reg sig_reg;

  // Remember the level of the previous cycle.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sig_reg <= 1'b0;
    end else begin
      sig_reg <= sig_in;
    end
  end

  // A rising edge by default, a falling edge when selected.
  assign edge_o = fall_sel ? (sig_reg & ~sig_in) : (~sig_reg & sig_in);

endmodule

// file: design/crs_out_stage.v
// Output stage: pulse, toggled level, driven low or released pin.
`timescale 1ns/1ps
`include "crs_counter_regs.vh"
module crs_out_stage (
  // Clock and reset.
  input  wire       sys_clk,
  input  wire       nrst,
  // Control from the counter core.
  input  wire [2:0] form,
  input  wire       tc,
  input  wire       set_cmd,
  input  wire       clr_cmd,
  input  wire       init_cmd,
  // Pin and state.
  output reg        out_o,
  output reg        out_oe,
  output reg        tog_o
);

  reg tc_reg;
  reg out_next;
  reg oe_next;

  // Toggle flip-flop, preset by software and flipped as the pulse ends.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tc_reg <= 1'b0;
      tog_o  <= 1'b0;
    end else begin
      tc_reg <= tc;
      if (init_cmd) begin
        tog_o <= 1'b0;
      end else if (set_cmd) begin
        tog_o <= 1'b1;
      end else if (clr_cmd) begin
        tog_o <= 1'b0;
      end else if (tc_reg & ~tc) begin
        tog_o <= ~tog_o;
      end
    end
  end

  always @* begin
    out_next = 1'b0;
    oe_next  = 1'b1;
    case (form)
      `CRS_FORM_LOW:      out_next = 1'b0;
      `CRS_FORM_PULSE_HI: out_next = tc;
      `CRS_FORM_PULSE_LO: out_next = ~tc;
      `CRS_FORM_TOGGLE:   out_next = tog_o;
      default:            oe_next  = 1'b0;
    endcase
  end

  // The pin is driven from flip-flops, one cycle behind the counter.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_o  <= 1'b0;
      out_oe <= 1'b1;
    end else begin
      out_o  <= out_next;
      out_oe <= oe_next;
    end
  end

endmodule

// file: design/crs_counter.v
// Counter group core: frequency-shift keying, hardware save, reload and Wishbone slave.
//
// How it works
// - gate low picks the load register.
// - gate high picks the hold register.
// - gate selects reload only, never counting.
// - armed counter repeats, reloading at each terminal.
// - repetition stops only on halt or init command.
// - save mode waits for armed gate edge.
// - once triggered, counts regardless of gate.
// - gate edges while running copy count to hold.
// - save-mode terminal reloads from load, steps once more on the next source edge, then stops.
// - resumes on first source edge after trigger.
// - reset or init sets mode to 0800.
// - low three mode bits choose output form.
// - terminal at 0001 down, 9999, ffff up.
// - terminal lasts one source period unless a load or init command clears it.
// - terminal reloads instead of passing zero.
// - toggled output flips at terminal trailing edge.
// - minimum one-shot toggles on second pulse.
// - set and clear commands fix toggle level.
// - reload select zero always reloads from load.
// - polarity bit picks rising or falling source.
`timescale 1ns/1ps
`include "crs_counter_regs.vh"
module crs_counter #(
  parameter ADR_W = 8
) (
  // Clock and reset.
  input  wire             sys_clk,
  input  wire             nrst,
  // Wishbone slave.
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [ADR_W-1:0] wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  // Source and gate pins.
  input  wire             src_in,
  input  wire             gate_in,
  // Output pin and terminal count.
  output wire             out_o,
  output wire             out_oe,
  output wire             tc_o
);

  // Software visible state.
  reg  [15:0] mode_reg;
  reg  [15:0] load_reg;
  reg  [15:0] hold_reg;
  reg         ctrl_reg;

  // Counting state.
  reg  [15:0] cnt_reg;
  reg  [15:0] cnt_next;
  reg         armed_reg;
  reg         run_reg;
  reg         tc_reg;

  // Bus decode.
  wire        wb_req;
  wire        wb_wr;
  wire [7:0]  adr;
  wire [ADR_W+7:0] adr_ext;
  wire        wr_mode;
  wire        wr_load;
  wire        wr_hold;
  wire        wr_cmd;
  wire        wr_ctrl;
  reg  [31:0] rd_data;

  // Commands.
  wire        c_arm;
  wire        c_load;
  wire        c_halt;
  wire        c_set;
  wire        c_clr;
  wire        c_init;

  // Mode decode and counting terms.
  wire        fsk_mode;
  wire        save_mode;
  wire        once_mode;
  wire        from_hold;
  wire [15:0] reload_val;
  wire        src_edge;
  wire        gate_rise;
  wire        count_en;
  wire        count_ev;
  wire        pre_tc;
  wire        count_up;
  wire        tog_lvl;
  wire [15:0] bcd_next;
  wire [15:0] bin_next;
  wire [4:0]  bcd_c;

  // The request is answered one cycle after it appears.
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr  = wb_req & wb_ack_o & wb_we_i;
  // Word-align the address and widen it so that the cut to eight bits is explicit.
  assign adr_ext = {8'h00, wb_adr_i[ADR_W-1:2], 2'b00};
  assign adr     = adr_ext[7:0];

  // Writes take effect on the edge where the master sees the answer.
  assign wr_mode = wb_wr & (adr == `CRS_OFF_MODE);
  assign wr_load = wb_wr & (adr == `CRS_OFF_LOAD);
  assign wr_hold = wb_wr & (adr == `CRS_OFF_HOLD);
  assign wr_cmd  = wb_wr & (adr == `CRS_OFF_CMD) & wb_sel_i[0];
  assign wr_ctrl = wb_wr & (adr == `CRS_OFF_CTRL) & wb_sel_i[0];

  assign c_arm  = wr_cmd & (wb_dat_i[`CRS_CMD_ARM] | wb_dat_i[`CRS_CMD_LDARM]);
  assign c_load = wr_cmd & (wb_dat_i[`CRS_CMD_LOAD] | wb_dat_i[`CRS_CMD_LDARM]);
  assign c_halt = wr_cmd & wb_dat_i[`CRS_CMD_HALT];
  assign c_set  = wr_cmd & wb_dat_i[`CRS_CMD_SET];
  assign c_clr  = wr_cmd & wb_dat_i[`CRS_CMD_CLR];
  assign c_init = wr_cmd & wb_dat_i[`CRS_CMD_INIT];

  // Frequency-shift keying: no gating, special, reload select and repeat bits set.
  assign fsk_mode  = (mode_reg[`CRS_GATE_MSB:`CRS_GATE_LSB] == `CRS_GATE_NONE) &
                     mode_reg[`CRS_SPECIAL_BIT] &
                     mode_reg[`CRS_RELOAD_BIT] &
                     mode_reg[`CRS_REPEAT_BIT];
  assign save_mode = ctrl_reg & ~fsk_mode;
  assign once_mode = ~fsk_mode & ~save_mode & ~mode_reg[`CRS_REPEAT_BIT];

  assign from_hold  = fsk_mode & mode_reg[`CRS_RELOAD_BIT] & gate_in;
  assign reload_val = from_hold ? hold_reg : load_reg;

  crs_edge_det u_src_edge (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .sig_in   (src_in),
    .fall_sel (mode_reg[`CRS_POL_BIT]),
    .edge_o   (src_edge)
  );

  // The active-going gate edge starts or samples the save mode.
  crs_edge_det u_gate_edge (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .sig_in   (gate_in),
    .fall_sel (1'b0),
    .edge_o   (gate_rise)
  );

  assign count_en = armed_reg & (save_mode ? run_reg : 1'b1);

  assign count_ev = src_edge & (tc_reg | count_en);

  assign count_up = mode_reg[`CRS_DIR_BIT];
  assign pre_tc   = count_up ?
                    (mode_reg[`CRS_BCD_BIT] ? (cnt_reg == `CRS_PRE_BCD_UP)
                                            : (cnt_reg == `CRS_PRE_BIN_UP)) :
                    (cnt_reg == `CRS_PRE_DOWN);

  // Binary step.
  assign bin_next = count_up ? cnt_reg + 16'h0001 : cnt_reg - 16'h0001;

  // Decimal step, one digit per loop pass with a carry chain.
  assign bcd_c[0] = 1'b1;
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_bcd
      wire [3:0] dig;
      assign dig = cnt_reg[4*i+3:4*i];
      assign bcd_next[4*i+3:4*i] = ~bcd_c[i] ? dig :
                                   count_up ? ((dig == 4'h9) ? 4'h0 : dig + 4'h1) :
                                              ((dig == 4'h0) ? 4'h9 : dig - 4'h1);
      assign bcd_c[i+1] = bcd_c[i] & (count_up ? (dig == 4'h9) : (dig == 4'h0));
    end
  endgenerate

  // Next counter value: a command load wins over a count in the same cycle.
  always @* begin
    cnt_next = cnt_reg;
    if (c_load) begin
      cnt_next = reload_val;
    end else if (count_ev) begin
      if (pre_tc) begin
        cnt_next = reload_val;
      end else begin
        cnt_next = mode_reg[`CRS_BCD_BIT] ? bcd_next : bin_next;
      end
    end
  end

  // Counter and terminal count flag.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= `CRS_CNT_RESET;
      tc_reg  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (c_init | c_load) begin
        tc_reg <= 1'b0;
      end else if (count_ev) begin
        tc_reg <= pre_tc;
      end
    end
  end

  // Arm state; arming wins over an automatic disarm in the same cycle.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= 1'b0;
    end else begin
      if (c_init | c_halt) begin
        armed_reg <= 1'b0;
      end else if (c_arm) begin
        armed_reg <= 1'b1;
      end else if (once_mode & count_ev & pre_tc & armed_reg) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // Running flag of the save mode.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_reg <= 1'b0;
    end else begin
      if (c_init | c_halt) begin
        run_reg <= 1'b0;
      end else if (save_mode & armed_reg & gate_rise & ~run_reg) begin
        run_reg <= 1'b1;
      end else if (save_mode & run_reg & count_ev & pre_tc) begin
        run_reg <= 1'b0;
      end
    end
  end

  // Mode register with byte enables; init restores the reset pattern.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= `CRS_MODE_RESET;
    end else begin
      if (c_init) begin
        mode_reg <= `CRS_MODE_RESET;
      end else if (wr_mode) begin
        if (wb_sel_i[0]) begin
          mode_reg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          mode_reg[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // Load register and save-mode enable.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      load_reg <= `CRS_LOAD_RESET;
      ctrl_reg <= 1'b0;
    end else begin
      if (wr_load & wb_sel_i[0]) begin
        load_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wr_load & wb_sel_i[1]) begin
        load_reg[15:8] <= wb_dat_i[15:8];
      end
      if (wr_ctrl) begin
        ctrl_reg <= wb_dat_i[`CRS_CTRL_SAVE];
      end
    end
  end

  // Hold register; a hardware save beats a software write in the same cycle.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hold_reg <= `CRS_HOLD_RESET;
    end else begin
      if (save_mode & armed_reg & run_reg & gate_rise) begin
        hold_reg <= cnt_reg;
      end else if (wr_hold) begin
        if (wb_sel_i[0]) begin
          hold_reg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          hold_reg[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // Read multiplexer; unmapped offsets and the command register read zero.
  always @* begin
    rd_data = 32'h0000_0000;
    case (adr)
      `CRS_OFF_MODE: rd_data = {16'h0000, mode_reg};
      `CRS_OFF_LOAD: rd_data = {16'h0000, load_reg};
      `CRS_OFF_HOLD: rd_data = {16'h0000, hold_reg};
      `CRS_OFF_STAT: rd_data = {28'h0000000, tog_lvl, tc_reg, run_reg, armed_reg};
      `CRS_OFF_CNT:  rd_data = {16'h0000, cnt_reg};
      `CRS_OFF_CTRL: rd_data = {31'h00000000, ctrl_reg};
      default:       rd_data = 32'h0000_0000;
    endcase
  end

  // Answer each request after one cycle and drop the answer the cycle after.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req & ~wb_ack_o & ~wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // Output pin logic.
  crs_out_stage u_out (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .form     (mode_reg[`CRS_FORM_MSB:`CRS_FORM_LSB]),
    .tc       (tc_reg),
    .set_cmd  (c_set),
    .clr_cmd  (c_clr),
    .init_cmd (c_init),
    .out_o    (out_o),
    .out_oe   (out_oe),
    .tog_o    (tog_lvl)
  );

  // The terminal count feeds a neighbouring counter directly.
  assign tc_o = tc_reg;

endmodule

// file: tb/crs_counter_monitor.sv
// Checker for bus handshake, terminal count timing and output pin behaviour.
`timescale 1ns/1ps
module crs_counter_monitor (
  // Clock and reset.
  input logic        sys_clk,
  input logic        nrst,
  // Bus signals.
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  // Pins.
  input logic        src_in,
  input logic        out_o,
  input logic        out_oe,
  input logic        tc_o
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // A request taken while idle, and its single-cycle answer.
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_one_cycle: assert property (s_req |=> s_ans)
    else $error("ack late or held");
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_tc_holds: assert property (tc_o && !wb_ack_o && src_in == $past(src_in) |=> tc_o)
    else $error("terminal count dropped without source edge");
  a_tc_rise_cause: assert property ($rose(tc_o) |->
    $past(src_in) != $past(src_in, 2) || $past(wb_ack_o))
    else $error("terminal count rose without cause");
  a_tc_fall_cause: assert property ($fell(tc_o) |->
    $past(src_in) != $past(src_in, 2) || $past(wb_ack_o))
    else $error("terminal count fell without cause");
  a_off_pin_low: assert property (!out_oe |-> !out_o)
    else $error("released pin shows high");
  a_out_cause: assert property ($changed(out_o) |->
    $past(tc_o) != $past(tc_o, 2) || $past(tc_o, 2) != $past(tc_o, 3) ||
    $past(tc_o, 3) != $past(tc_o, 4) || $past(wb_ack_o) || $past(wb_ack_o, 2) ||
    $past(wb_ack_o, 3))
    else $error("output moved without terminal count or command");
  a_oe_cause: assert property ($changed(out_oe) |->
    $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("output enable moved without a write");
endmodule
bind crs_counter crs_counter_monitor mon_u (.sys_clk(sys_clk), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .src_in(src_in), .out_o(out_o), .out_oe(out_oe), .tc_o(tc_o));

// file: tb/crs_pin_model.sv
// Far-side pin model: count source while running and registered gate pin.
`timescale 1ns/1ps
module crs_pin_model #(
  parameter int HALF = 2
) (
  // Clock and reset.
  input  logic sys_clk,
  input  logic nrst,
  // Requests from the bench.
  input  logic run,
  input  logic gate_req,
  // Pins toward the counter.
  output logic src_in,
  output logic gate_in
);
  int ph;
  // Each source level lasts HALF cycles; the source rests low between runs.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ph      <= 0;
      src_in  <= 1'b0;
      gate_in <= 1'b0;
    end else begin
      gate_in <= gate_req;
      ph      <= (ph + 1) % HALF;
      if (!run)
        src_in <= 1'b0;
      else if (ph == HALF - 1)
        src_in <= ~src_in;
    end
  end
endmodule

// file: tb/crs_counter_tb.sv
// Self-checking bench for the counter group.
`timescale 1ns/1ps
`include "crs_counter_regs.vh"
module crs_counter_tb;
  logic        sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        src_in, gate_in, out_o, out_oe, tc_o, run, gate_req, o1;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, v;
  int          errors, samples_checked, p1, p2;
  crs_counter dut_u (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_in(src_in),
    .gate_in(gate_in), .out_o(out_o), .out_oe(out_oe), .tc_o(tc_o));
  crs_pin_model pm_u (.sys_clk(sys_clk), .nrst(nrst), .run(run), .gate_req(gate_req),
    .src_in(src_in), .gate_in(gate_in));
  // Clock of 50 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic bus cycle; read data lands in q.
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Cycles until the next rising terminal count, bounded.
  task wait_rise(output int c);
    c = 0;
    while (tc_o !== 1'b0 && c < 400) begin
      @(posedge sys_clk);
      c++;
    end
    while (tc_o !== 1'b1 && c < 400) begin
      @(posedge sys_clk);
      c++;
    end
    if (c >= 400) begin
      errors++;
      final_report;
    end
  endtask
  task t_reset;
    wb(1'b0, `CRS_OFF_MODE, 32'h0);
    check(q, 32'h0800);
    check({out_oe, out_o}, 2'h2);
    wb(1'b0, 8'h1c, 32'h0);
    check(q, 32'h0);
    $display("test reset done");
  endtask
  task t_fsk;
    wb(1'b1, `CRS_OFF_MODE, 32'h00e2);
    wb(1'b1, `CRS_OFF_LOAD, 32'h3);
    wb(1'b1, `CRS_OFF_HOLD, 32'h5);
    wb(1'b1, `CRS_OFF_CMD, 32'h2);
    wb(1'b0, `CRS_OFF_CNT, 32'h0);
    check(q, 32'h3);
    gate_req <= 1'b1;
    idle(2);
    wb(1'b1, `CRS_OFF_CMD, 32'h2);
    wb(1'b0, `CRS_OFF_CNT, 32'h0);
    check(q, 32'h5);
    wb(1'b1, `CRS_OFF_CMD, 32'h1);
    run <= 1'b1;
    wait_rise(p1);
    wait_rise(p1);
    o1 = out_o;
    wait_rise(p2);
    check(p2, 20);
    check(out_o ^ o1, 1);
    gate_req <= 1'b0;
    wait_rise(p1);
    wait_rise(p2);
    check(p2, 12);
    wb(1'b1, `CRS_OFF_CMD, 32'h8);
    idle(8);
    wb(1'b0, `CRS_OFF_CNT, 32'h0);
    v = q;
    idle(30);
    wb(1'b0, `CRS_OFF_CNT, 32'h0);
    check(q, v);
    $display("test fsk done");
  endtask
  task t_save;
    wb(1'b1, `CRS_OFF_CTRL, 32'h1);
    wb(1'b1, `CRS_OFF_MODE, 32'h0801);
    wb(1'b1, `CRS_OFF_LOAD, 32'h8);
    gate_req <= 1'b1;
    idle(4);
    gate_req <= 1'b0;
    wb(1'b1, `CRS_OFF_CMD, 32'h4);
    idle(20);
    wb(1'b0, `CRS_OFF_CNT, 32'h0);
    check(q, 32'h8);
    gate_req <= 1'b1;
    idle(12);
    gate_req <= 1'b0;
    idle(3);
    gate_req <= 1'b1;
    idle(3);
    wb(1'b0, `CRS_OFF_STAT, 32'h0);
    check(q[`CRS_ST_RUN], 1);
    wb(1'b0, `CRS_OFF_HOLD, 32'h0);
    v = q;
    wb(1'b0, `CRS_OFF_CNT, 32'h0);
    check(q < v && v < 8 && v > 0, 1);
    wait_rise(p1);
    @(posedge sys_clk);
    check(out_o, 1);
    idle(40);
    wb(1'b0, `CRS_OFF_CNT, 32'h0);
    check(q, 32'h7);
    wb(1'b0, `CRS_OFF_STAT, 32'h0);
    check(q[`CRS_ST_RUN], 0);
    gate_req <= 1'b0;
    idle(2);
    gate_req <= 1'b1;
    idle(10);
    wb(1'b0, `CRS_OFF_CNT, 32'h0);
    check(q < 7, 1);
    wb(1'b1, `CRS_OFF_CMD, 32'h8);
    wb(1'b1, `CRS_OFF_CTRL, 32'h0);
    run <= 1'b0;
    $display("test save done");
  endtask
  task t_forms;
    logic [2:0] fm [4];
    logic [1:0] ex [4];
    fm = '{`CRS_FORM_LOW, `CRS_FORM_OFF, `CRS_FORM_PULSE_LO, `CRS_FORM_PULSE_HI};
    ex = '{2'h2, 2'h0, 2'h3, 2'h2};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `CRS_OFF_MODE, {29'h00000100, fm[i]});
      idle(3);
      check({out_oe, out_o}, ex[i]);
    end
    wb(1'b1, `CRS_OFF_MODE, 32'h0802);
    wb(1'b1, `CRS_OFF_CMD, 32'h10);
    idle(3);
    check(out_o, 1);
    wb(1'b1, `CRS_OFF_CMD, 32'h20);
    idle(3);
    check(out_o, 0);
    wb(1'b1, `CRS_OFF_CMD, 32'h40);
    wb(1'b0, `CRS_OFF_MODE, 32'h0);
    check(q, 32'h0800);
    $display("test forms done");
  endtask
  // Up-counting terminal values and source polarity; the level of src_in
  // seen just after terminal count shows which edge was counted.
  task t_ends;
    wb(1'b1, `CRS_OFF_MODE, 32'h0828);
    wb(1'b1, `CRS_OFF_LOAD, 32'hfffd);
    wb(1'b1, `CRS_OFF_CMD, 32'h4);
    run <= 1'b1;
    wait_rise(p1);
    check(src_in, 1);
    wait_rise(p2);
    check(p2, 12);
    wb(1'b1, `CRS_OFF_CMD, 32'h8);
    wb(1'b1, `CRS_OFF_MODE, 32'h1838);
    wb(1'b1, `CRS_OFF_LOAD, 32'h9997);
    wb(1'b1, `CRS_OFF_CMD, 32'h4);
    wait_rise(p1);
    check(src_in, 0);
    wait_rise(p2);
    check(p2, 12);
    wb(1'b1, `CRS_OFF_CMD, 32'h8);
    run <= 1'b0;
    $display("test ends done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence: reset for six cycles, then the tests.
  initial begin
    nrst = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    run = 1'b0;
    gate_req = 1'b0;
    errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    t_fsk;
    t_save;
    t_forms;
    t_ends;
    final_report;
  end
  // Watchdog at 40000 cycles, well beyond the expected few hundred.
  initial begin
    #2000000;
    errors++;
    final_report;
  end
endmodule
